// file: hw/bus_fault_map.vh
`ifndef BUS_FAULT_MAP_VH
`define BUS_FAULT_MAP_VH

// register addresses (byte addresses, all multiples of four)
`define ADDR_W 32
`define ADDR_CORE_REVISION_INFO 32'h01812000
`define ADDR_BUS_FAULT_STATUS 32'h01820400
`define ADDR_BUS_FAULT_CLEAR 32'h01820404

// bus_fault_status field layout
`define SRC_HI 31
`define SRC_LO 29
`define TAG_HI 11
`define TAG_LO 8
`define RES_HI 2
`define RES_LO 0
`define SRC_W 3
`define TAG_W 4
`define RES_W 3

// fault source encodings
`define SRC_NONE 3'h0
`define SRC_DMA_RD 3'h1
`define SRC_DMA_WR 3'h2
`define SRC_CFG_RD 3'h3
`define SRC_CFG_WR 3'h4

// response status encodings
`define RESP_OK 3'h0
`define RESP_ADDR 3'h1
`define RESP_PRIV 3'h2
`define RESP_TMO 3'h3
`define RESP_DATA 3'h4
`define RESP_EXCL 3'h7

// clear register bit
`define WIPE_BIT 0

// revision field
`define REV_W 16
`define REV_PAD 16'h0000
`define ZERO32 32'h00000000
`define ZERO_TAG 4'h0

`endif

// file: hw/fault_detect.v
`include "bus_fault_map.vh"
`default_nettype none

// picks the one failing response of this cycle, by fixed priority
module fault_detect (
	input wire dma_rd_vld_i, // master_dma_bus read response valid
	input wire [2:0] dma_rd_status_i, // read response status
	input wire [3:0] dma_rd_tag_i, // read_tag
	input wire dma_rd_tag_known_i, // read_tag recognised
	input wire dma_wr_vld_i, // master_dma_bus write response valid
	input wire [2:0] dma_wr_status_i, // write response status
	input wire [3:0] dma_wr_tag_i, // write_tag
	input wire dma_wr_tag_known_i, // write_tag recognised
	input wire cfg_rd_vld_i, // config read response valid
	input wire [2:0] cfg_rd_status_i, // config read status
	input wire [3:0] cfg_rd_tag_i, // config read_tag
	input wire cfg_rd_tag_known_i, // config read_tag recognised
	input wire cfg_wr_vld_i, // config write response valid
	input wire [2:0] cfg_wr_status_i, // config write status
	input wire [3:0] cfg_wr_tag_i, // config write_tag
	input wire cfg_wr_tag_known_i, // config write_tag recognised
	output reg hit_o, // some response failed this cycle
	output reg [2:0] src_o, // fault source code
	output reg [3:0] tag_o, // failing transaction tag
	output reg [2:0] res_o // result field to record
);

	wire dma_rd_bad;
	wire dma_wr_bad;
	wire cfg_rd_bad;
	wire cfg_wr_bad;

	// a non-success status or an unknown tag is a failure
	assign dma_rd_bad = dma_rd_vld_i & ((dma_rd_status_i != `RESP_OK) | ~dma_rd_tag_known_i);
	assign dma_wr_bad = dma_wr_vld_i & ((dma_wr_status_i != `RESP_OK) | ~dma_wr_tag_known_i);
	assign cfg_rd_bad = cfg_rd_vld_i & ((cfg_rd_status_i != `RESP_OK) | ~cfg_rd_tag_known_i);
	assign cfg_wr_bad = cfg_wr_vld_i & ((cfg_wr_status_i != `RESP_OK) | ~cfg_wr_tag_known_i);

	// lowest source code wins when several fail together; only one record fits
	always @*
	begin
		hit_o = 1'b1;
		src_o = `SRC_NONE;
		tag_o = `ZERO_TAG;
		res_o = `RESP_OK;
		if (dma_rd_bad)
		begin
			src_o = `SRC_DMA_RD;
			tag_o = dma_rd_tag_i;
			res_o = dma_rd_tag_known_i ? dma_rd_status_i : `RESP_OK; // see R5
		end
		else if (dma_wr_bad)
		begin
			src_o = `SRC_DMA_WR;
			tag_o = dma_wr_tag_i;
			res_o = dma_wr_tag_known_i ? dma_wr_status_i : `RESP_OK; // see R5
		end
		else if (cfg_rd_bad)
		begin
			src_o = `SRC_CFG_RD;
			tag_o = cfg_rd_tag_i;
			res_o = cfg_rd_tag_known_i ? cfg_rd_status_i : `RESP_OK; // see R5
		end
		else if (cfg_wr_bad)
		begin
			src_o = `SRC_CFG_WR;
			tag_o = cfg_wr_tag_i;
			res_o = cfg_wr_tag_known_i ? cfg_wr_status_i : `RESP_OK; // see R5
		end
		else
			hit_o = 1'b0;
	end

endmodule // fault_detect

`default_nettype wire

// file: hw/bus_error_capture_regs.v
// Summary of operation
// R1 - a failed read or write on either bus is latched into bus_fault_status
// R2 - bits 31-29 give source: 1 dma read, 2 dma write, 3 cfg read, 4 cfg write
// R3 - the failing read_tag or write_tag is stored in bits 11-8
// R4 - bits 2-0 hold the returned status code of the failing response
// R5 - success causes no capture; unknown tag is captured with result zero
// R6 - writing one to clear bit 0 zeroes the whole status register; a failure arriving in that same cycle is captured instead
// R7 - writing zero to the clear bit leaves the status register unchanged
// R8 - after one capture, later errors are neither recorded nor overwrite it
// R9 - revision register is read-only: number in 15-0, zeros above
// R10 - status reads zero after reset and reserved bits always read zero
//
// Strobed register access is this design's own decision.
`include "bus_fault_map.vh"
`default_nettype none

module bus_error_capture_regs #(
	parameter [15:0] REVISION = 16'h0001 // arbitrary value, set per silicon revision
) (
	input wire sys_clk_i, // 40 MHz clock
	input wire rst_n_i, // synchronous reset, active low
	input wire [31:0] addr_i, // register byte address
	input wire [31:0] wdata_i, // write data
	input wire wr_i, // write strobe
	input wire rd_i, // read strobe
	output reg [31:0] rdata_o, // read data, valid the cycle after rd_i
	output reg fault_held_o, // a fault record is held
	input wire dma_rd_vld_i, // master_dma_bus read response valid
	input wire [2:0] dma_rd_status_i, // read response status
	input wire [3:0] dma_rd_tag_i, // read_tag
	input wire dma_rd_tag_known_i, // read_tag recognised
	input wire dma_wr_vld_i, // master_dma_bus write response valid
	input wire [2:0] dma_wr_status_i, // write response status
	input wire [3:0] dma_wr_tag_i, // write_tag
	input wire dma_wr_tag_known_i, // write_tag recognised
	input wire cfg_rd_vld_i, // config read response valid
	input wire [2:0] cfg_rd_status_i, // config read status
	input wire [3:0] cfg_rd_tag_i, // config read_tag
	input wire cfg_rd_tag_known_i, // config read_tag recognised
	input wire cfg_wr_vld_i, // config write response valid
	input wire [2:0] cfg_wr_status_i, // config write status
	input wire [3:0] cfg_wr_tag_i, // config write_tag
	input wire cfg_wr_tag_known_i // config write_tag recognised
);

	reg [2:0] src_r;
	reg [3:0] tag_r;
	reg [2:0] res_r;
	reg [2:0] src_nxt;
	reg [3:0] tag_nxt;
	reg [2:0] res_nxt;
	wire hit;
	wire [2:0] hit_src;
	wire [3:0] hit_tag;
	wire [2:0] hit_res;
	wire armed;
	wire wipe;
	wire [31:0] status_word;

	fault_detect u_detect (
		.dma_rd_vld_i(dma_rd_vld_i),
		.dma_rd_status_i(dma_rd_status_i),
		.dma_rd_tag_i(dma_rd_tag_i),
		.dma_rd_tag_known_i(dma_rd_tag_known_i),
		.dma_wr_vld_i(dma_wr_vld_i),
		.dma_wr_status_i(dma_wr_status_i),
		.dma_wr_tag_i(dma_wr_tag_i),
		.dma_wr_tag_known_i(dma_wr_tag_known_i),
		.cfg_rd_vld_i(cfg_rd_vld_i),
		.cfg_rd_status_i(cfg_rd_status_i),
		.cfg_rd_tag_i(cfg_rd_tag_i),
		.cfg_rd_tag_known_i(cfg_rd_tag_known_i),
		.cfg_wr_vld_i(cfg_wr_vld_i),
		.cfg_wr_status_i(cfg_wr_status_i),
		.cfg_wr_tag_i(cfg_wr_tag_i),
		.cfg_wr_tag_known_i(cfg_wr_tag_known_i),
		.hit_o(hit),
		.src_o(hit_src),
		.tag_o(hit_tag),
		.res_o(hit_res)
	);

	// a zero source field means nothing held, so capture is armed
	assign armed = (src_r == `SRC_NONE); // see R8
	assign wipe = wr_i & (addr_i == `ADDR_BUS_FAULT_CLEAR) & wdata_i[`WIPE_BIT]; // see R6 see R7

	// event in the same cycle as a wipe wins, so no fault is lost
	always @*
	begin
		src_nxt = src_r;
		tag_nxt = tag_r;
		res_nxt = res_r;
		if (hit & (armed | wipe)) // see R1 see R8
		begin
			src_nxt = hit_src; // see R2
			tag_nxt = hit_tag; // see R3
			res_nxt = hit_res; // see R4
		end
		else if (wipe)
		begin
			src_nxt = `SRC_NONE; // see R6
			tag_nxt = `ZERO_TAG;
			res_nxt = `RESP_OK;
		end
	end

	// capture record
	always @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			src_r <= `SRC_NONE; // see R10
			tag_r <= `ZERO_TAG;
			res_r <= `RESP_OK;
		end
		else
		begin
			src_r <= src_nxt;
			tag_r <= tag_nxt;
			res_r <= res_nxt;
		end
	end

	// reserved bits tied to zero
	assign status_word = {src_r, 17'h00000, tag_r, 5'h00, res_r}; // see R10

	// read data registered; unmapped and write-only addresses read zero
	always @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			rdata_o <= `ZERO32;
			fault_held_o <= 1'b0;
		end
		else
		begin
			fault_held_o <= (src_nxt != `SRC_NONE);
			if (!rd_i)
				rdata_o <= `ZERO32;
			else if (addr_i == `ADDR_CORE_REVISION_INFO)
				rdata_o <= {`REV_PAD, REVISION}; // see R9
			else if (addr_i == `ADDR_BUS_FAULT_STATUS)
				rdata_o <= status_word;
			else
				rdata_o <= `ZERO32;
		end
	end

endmodule // bus_error_capture_regs

`default_nettype wire

// file: sim/resp_slave_model.sv
`default_nettype none
// stand-in for the slaves that answer on both external buses
module resp_slave_model (
	input wire logic sys_clk_i, // clock
	input wire logic [3:0] go_i, // channel to answer on
	input wire logic [7:0] rsp_i, // known, tag, status
	output logic [3:0] vld_o, // response valid pulses
	output logic [7:0] rsp_o // known, tag, status
);
	timeunit 1ns;
	timeprecision 100ps;
	// idle cycles show the inverse fields so a stale response never looks valid
	always @(posedge sys_clk_i)
	begin
		vld_o <= go_i;
		rsp_o <= |go_i ? rsp_i : ~rsp_i;
	end
endmodule // resp_slave_model
`default_nettype wire

// file: sim/bus_fault_monitor.sv
`include "bus_fault_map.vh"
`default_nettype none
module bus_fault_monitor #(
	parameter logic [15:0] REVISION = 16'h0001 // arbitrary value
) (
	input wire logic sys_clk_i, // clock
	input wire logic rst_n_i, // reset
	input wire logic [31:0] addr_i, // address
	input wire logic [31:0] wdata_i, // write data
	input wire logic wr_i, // write strobe
	input wire logic rd_i, // read strobe
	input wire logic [31:0] rdata_o, // read data
	input wire logic fault_held_o, // record held
	input wire logic dma_rd_vld_i, // dma read valid
	input wire logic [2:0] dma_rd_status_i, // dma read status
	input wire logic dma_wr_vld_i, // dma write valid
	input wire logic cfg_rd_vld_i, // cfg read valid
	input wire logic cfg_wr_vld_i // cfg write valid
);
	timeunit 1ns;
	timeprecision 100ps;
	// address decode and a clear write seen from the ports
	wire rev_a = addr_i == `ADDR_CORE_REVISION_INFO;
	wire st_a = addr_i == `ADDR_BUS_FAULT_STATUS;
	wire clr_w = wr_i && addr_i == `ADDR_BUS_FAULT_CLEAR && wdata_i[`WIPE_BIT];
	wire any_vld = dma_rd_vld_i | dma_wr_vld_i | cfg_rd_vld_i | cfg_wr_vld_i;
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	sequence s_st_rd;
		rd_i && st_a;
	endsequence
	sequence s_dma_fail;
		!fault_held_o && dma_rd_vld_i && dma_rd_status_i != `RESP_OK;
	endsequence
	property p_reset;
		disable iff (1'b0) !rst_n_i |=> rdata_o == `ZERO32 && !fault_held_o;
	endproperty
	property p_capture;
		s_dma_fail |=> fault_held_o;
	endproperty
	property p_hold;
		fault_held_o && !clr_w |=> fault_held_o;
	endproperty
	property p_clear;
		clr_w && !any_vld |=> !fault_held_o;
	endproperty
	property p_rev;
		rd_i && rev_a |=> rdata_o == {`REV_PAD, REVISION};
	endproperty
	property p_idle;
		s_st_rd ##0 (!fault_held_o && !any_vld) |=> rdata_o == `ZERO32;
	endproperty
	property p_fields;
		s_st_rd ##0 fault_held_o |=> rdata_o[31:29] inside {[3'h1:3'h4]} && rdata_o[28:12] == 17'h00000
			&& rdata_o[7:3] == 5'h00;
	endproperty
	property p_other;
		rd_i && !rev_a && !st_a |=> rdata_o == `ZERO32;
	endproperty
	a_reset: assert property (p_reset) else $error("reset left outputs set");
	a_capture: assert property (p_capture) else $error("failure not captured");
	a_hold: assert property (p_hold) else $error("record lost");
	a_clear: assert property (p_clear) else $error("clear ignored");
	a_rev: assert property (p_rev) else $error("bad revision");
	a_idle: assert property (p_idle) else $error("empty status not zero");
	a_fields: assert property (p_fields) else $error("bad status fields");
	a_other: assert property (p_other) else $error("other read not zero");
endmodule // bus_fault_monitor
bind bus_error_capture_regs bus_fault_monitor #(.REVISION(REVISION)) u_bus_fault_monitor (.*);
`default_nettype wire

// file: sim/bus_error_capture_regs_tb.sv
`include "bus_fault_map.vh"
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; $display("BAD %s exp %h got %h", n, e, g); end end
module bus_error_capture_regs_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [15:0] REV = 16'h0A5C; // arbitrary value
	logic sys_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [31:0] addr_i = 32'h00000000;
	logic [31:0] wdata_i = 32'h00000000;
	logic [31:0] rdata_o, d, e;
	logic fault_held_o;
	logic [3:0] go = 4'h0;
	logic [3:0] v;
	logic [7:0] rsp = 8'h00;
	logic [7:0] q;
	logic [7:0] r;
	logic [1:0] ch;
	int fail_count = 0;
	int num_checks = 0;
	// channel, known, tag, status, expected status word
	logic [41:0] rows [8] = '{{2'h3, 1'h1, 4'h5, 3'h1, 32'h20000501}, {2'h2, 1'h1, 4'hA, 3'h2, 32'h40000A02},
		{2'h1, 1'h1, 4'hF, 3'h3, 32'h60000F03}, {2'h0, 1'h1, 4'h0, 3'h4, 32'h80000004},
		{2'h3, 1'h1, 4'h3, 3'h7, 32'h20000307}, {2'h2, 1'h0, 4'h9, 3'h3, 32'h40000900},
		{2'h1, 1'h1, 4'h6, 3'h0, 32'h00000000}, {2'h0, 1'h0, 4'hC, 3'h0, 32'h80000C00}};
	resp_slave_model u_resp_slave_model (.sys_clk_i, .go_i(go), .rsp_i(rsp), .vld_o(v), .rsp_o(q));
	bus_error_capture_regs #(.REVISION(REV)) u_bus_error_capture_regs (.sys_clk_i, .rst_n_i, .addr_i, .wdata_i,
		.wr_i, .rd_i, .rdata_o, .fault_held_o,
		.dma_rd_vld_i(v[3]), .dma_rd_status_i(q[2:0]), .dma_rd_tag_i(q[6:3]), .dma_rd_tag_known_i(q[7]),
		.dma_wr_vld_i(v[2]), .dma_wr_status_i(q[2:0]), .dma_wr_tag_i(q[6:3]), .dma_wr_tag_known_i(q[7]),
		.cfg_rd_vld_i(v[1]), .cfg_rd_status_i(q[2:0]), .cfg_rd_tag_i(q[6:3]), .cfg_rd_tag_known_i(q[7]),
		.cfg_wr_vld_i(v[0]), .cfg_wr_status_i(q[2:0]), .cfg_wr_tag_i(q[6:3]), .cfg_wr_tag_known_i(q[7]));
	always #12.5 sys_clk_i = ~sys_clk_i;
	task automatic end_sim;
		if (fail_count == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// bus cycles: strobes last one cycle, read data taken in the cycle after
	task automatic wr(input logic [31:0] a, input logic [31:0] w);
		addr_i <= a;
		wdata_i <= w;
		wr_i <= 1'b1;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [31:0] a, output logic [31:0] x);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
		#1;
		x = rdata_o;
		@(posedge sys_clk_i);
	endtask
	// one response pulse; the model adds a cycle, so capture lands at return
	task automatic inj(input logic [1:0] c, input logic [7:0] w);
		go <= 4'h1 << c;
		rsp <= w;
		@(posedge sys_clk_i);
		go <= 4'h0;
		@(posedge sys_clk_i);
	endtask
	initial
	begin
		#20us;
		fail_count++;
		end_sim();
	end
	initial
	begin
		repeat (6) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		@(posedge sys_clk_i);
		rd(`ADDR_BUS_FAULT_STATUS, d);
		`CHK("status", 32'h00000000, d)
		wr(`ADDR_CORE_REVISION_INFO, 32'hFFFFFFFF);
		rd(`ADDR_CORE_REVISION_INFO, d);
		`CHK("revision", {16'h0000, REV}, d)
		foreach (rows[i])
		begin
			{ch, r, e} = rows[i];
			inj(ch, r);
			rd(`ADDR_BUS_FAULT_STATUS, d);
			`CHK("captured", e, d)
			`CHK("held", |e[31:29], fault_held_o)
			wr(`ADDR_BUS_FAULT_CLEAR, 32'h00000001);
			rd(`ADDR_BUS_FAULT_STATUS, d);
			`CHK("cleared", 32'h00000000, d)
			`CHK("released", 1'b0, fault_held_o)
		end
		// second error and a clear write with bit 0 low must not disturb the first
		inj(2'h3, {1'h1, 4'h2, 3'h1});
		inj(2'h0, {1'h1, 4'h7, 3'h4});
		wr(`ADDR_BUS_FAULT_CLEAR, 32'hFFFFFFFE);
		rd(`ADDR_BUS_FAULT_STATUS, d);
		`CHK("first kept", 32'h20000201, d)
		// a failure landing in the very cycle of a clear write becomes the new record
		go <= 4'h4;
		rsp <= {1'h1, 4'h6, 3'h2};
		@(posedge sys_clk_i);
		go <= 4'h0;
		wr(`ADDR_BUS_FAULT_CLEAR, 32'h00000001);
		rd(`ADDR_BUS_FAULT_STATUS, d);
		`CHK("capture beats clear", 32'h40000602, d)
		rst_n_i <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		@(posedge sys_clk_i);
		rd(`ADDR_BUS_FAULT_STATUS, d);
		`CHK("status again", 32'h00000000, d)
		`CHK("held after reset", 1'b0, fault_held_o)
		rd(32'h01820408, d);
		`CHK("unmapped", 32'h00000000, d)
		end_sim();
	end
endmodule // bus_error_capture_regs_tb
`default_nettype wire
